// ===== acc_pkg.sv
package acc_pkg;
  localparam int ACC_NCH = 3;
  // Register byte addresses
  localparam logic [7:0] ACC_OFF_CTRL1 = 8'h00;
  localparam logic [7:0] ACC_OFF_CTRL2 = 8'h04;
  localparam logic [7:0] ACC_OFF_CTRL3 = 8'h08;
  localparam logic [7:0] ACC_OFF_STAT = 8'h0c;
  localparam logic [7:0] ACC_OFF_FLAG = 8'h10;
  localparam logic [7:0] ACC_OFF_IRQ_STS = 8'h14;
  localparam logic [7:0] ACC_OFF_IRQ_MSK = 8'h18;
  // Control register fields
  localparam int ACC_B_ENABLE = 7;
  localparam int ACC_B_DRIVE = 6;
  localparam int ACC_B_INVERT = 5;
  localparam int ACC_B_EDGE_HI = 4;
  localparam int ACC_B_EDGE_LO = 3;
  localparam int ACC_B_PLUS = 2;
  localparam int ACC_B_MINUS_HI = 1;
  localparam int ACC_B_MINUS_LO = 0;
  localparam int ACC_B_RESULT_LO = 5;
  localparam logic [7:0] ACC_CTRL_RST = 8'h00;
  localparam logic [2:0] ACC_FLAG_RST = 3'h0;
  localparam logic [2:0] ACC_RES_RST = 3'h0;
  // Edge select codes
  localparam logic [1:0] ACC_EDGE_NONE = 2'h0;
  localparam logic [1:0] ACC_EDGE_RISE = 2'h1;
  localparam logic [1:0] ACC_EDGE_FALL = 2'h2;
  localparam logic [1:0] ACC_EDGE_ANY = 2'h3;
  // Minus select codes
  localparam logic [1:0] ACC_MINUS_OWN_B = 2'h0;
  localparam logic [1:0] ACC_MINUS_OWN_C = 2'h1;
  localparam logic [1:0] ACC_MINUS_EXTRA = 2'h2;
  localparam logic [1:0] ACC_MINUS_BGAP = 2'h3;
  // Source code driven to the analog input multiplexer
  typedef enum logic [2:0] {
    ACC_SRC_OWN_B = 3'h0,
    ACC_SRC_OWN_C = 3'h1,
    ACC_SRC_SHARED_B = 3'h2,
    ACC_SRC_CH2_D = 3'h3,
    ACC_SRC_BGAP = 3'h4
  } acc_src_t;
endpackage

// ===== acc_top.sv
module acc_top
  import acc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [2:0] cmp_raw,
  input wire logic [2:0] pin_dir_input,
  output logic [2:0] cmp_enable,
  output logic [2:0] plus_ladder_sel,
  output logic [8:0] minus_src,
  output logic [2:0] channel_output_pin,
  output logic [2:0] channel_output_oe,
  output logic irq
);

  function automatic acc_src_t minus_decode(input logic [1:0] code, input int ch);
    acc_src_t s;
    s = ACC_SRC_OWN_B;
    unique case (code)
      ACC_MINUS_OWN_B: s = ACC_SRC_OWN_B;
      ACC_MINUS_OWN_C: s = ACC_SRC_OWN_C;
      ACC_MINUS_EXTRA: s = (ch == 1) ? ACC_SRC_CH2_D : ACC_SRC_SHARED_B;
      ACC_MINUS_BGAP: s = ACC_SRC_BGAP;
    endcase
    return s;
  endfunction

  logic [7:0] ctrl_reg [ACC_NCH];
  logic [2:0] sync1_reg, sync2_reg, result_reg, result_prev_reg, en_prev_reg;
  logic [2:0] flag_reg, irq_sts_reg, irq_msk_reg;
  logic [2:0] hit, auto_set, evt_set;
  logic [2:0] result_next;
  logic acc_take, wr_en;
  logic [31:0] rdata_next;
  logic err_next;

  // Answer one cycle into the access phase; the transfer completes there
  assign acc_take = psel && penable && pready;
  assign wr_en = acc_take && pwrite;

  always_comb begin
    rdata_next = 32'h0000_0000;
    err_next = 1'b0;
    unique case (paddr)
      ACC_OFF_CTRL1: rdata_next[7:0] = ctrl_reg[0];
      ACC_OFF_CTRL2: rdata_next[7:0] = ctrl_reg[1];
      ACC_OFF_CTRL3: rdata_next[7:0] = ctrl_reg[2];
      ACC_OFF_STAT: rdata_next[7:0] = {result_reg, 5'h00};
      ACC_OFF_FLAG: rdata_next[2:0] = flag_reg;
      ACC_OFF_IRQ_STS: rdata_next[2:0] = irq_sts_reg;
      ACC_OFF_IRQ_MSK: rdata_next[2:0] = irq_msk_reg;
      default: err_next = 1'b1;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && err_next;
      if (psel && penable && !pready && !pwrite) begin
        prdata <= rdata_next;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < ACC_NCH; i++) begin
        ctrl_reg[i] <= ACC_CTRL_RST;
      end
    end else if (wr_en) begin
      if (paddr == ACC_OFF_CTRL1) ctrl_reg[0] <= pwdata[7:0];
      if (paddr == ACC_OFF_CTRL2) ctrl_reg[1] <= pwdata[7:0];
      if (paddr == ACC_OFF_CTRL3) ctrl_reg[2] <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= ACC_RES_RST;
      sync2_reg <= ACC_RES_RST;
    end else begin
      // Raw bits may move at any time; only the second stage is read onward
      sync1_reg <= cmp_raw;
      sync2_reg <= sync1_reg;
    end
  end

  always_comb begin
    for (int i = 0; i < ACC_NCH; i++) begin
      // held low when off, then inverted
      result_next[i] = (ctrl_reg[i][ACC_B_ENABLE] & sync2_reg[i]) ^ ctrl_reg[i][ACC_B_INVERT];
    end
  end

  // Events compare against last cycle's result and also need the enable held from last cycle,
  // so the very first enabled cycle is not counted as a change.
  always_comb begin
    for (int i = 0; i < ACC_NCH; i++) begin
      hit[i] = 1'b0;
      if (ctrl_reg[i][ACC_B_ENABLE] && en_prev_reg[i]) begin
        unique case (ctrl_reg[i][ACC_B_EDGE_HI:ACC_B_EDGE_LO])
          ACC_EDGE_NONE: hit[i] = 1'b0;
          ACC_EDGE_RISE: hit[i] = result_reg[i] & ~result_prev_reg[i];
          ACC_EDGE_FALL: hit[i] = ~result_reg[i] & result_prev_reg[i];
          ACC_EDGE_ANY: hit[i] = result_reg[i] ^ result_prev_reg[i];
        endcase
      end
    end
    // selecting any-change mode raises the flag
    auto_set = 3'h0;
    if (wr_en && pwdata[ACC_B_EDGE_HI:ACC_B_EDGE_LO] == ACC_EDGE_ANY) begin
      auto_set[0] = (paddr == ACC_OFF_CTRL1);
      auto_set[1] = (paddr == ACC_OFF_CTRL2);
      auto_set[2] = (paddr == ACC_OFF_CTRL3);
    end
    evt_set = hit | auto_set;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_reg <= ACC_RES_RST;
      result_prev_reg <= ACC_RES_RST;
      en_prev_reg <= 3'h0;
    end else begin
      result_reg <= result_next;
      result_prev_reg <= result_reg;
      en_prev_reg <= {ctrl_reg[2][ACC_B_ENABLE], ctrl_reg[1][ACC_B_ENABLE], ctrl_reg[0][ACC_B_ENABLE]};
    end
  end

  // flags follow the write; a new event wins over a clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_reg <= ACC_FLAG_RST;
    end else if (wr_en && paddr == ACC_OFF_FLAG) begin
      flag_reg <= pwdata[2:0] | evt_set;
    end else begin
      flag_reg <= flag_reg | evt_set;
    end
  end

  // Interrupt status is write-one-to-clear, separate from the flags above
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_sts_reg <= ACC_FLAG_RST;
      irq_msk_reg <= ACC_FLAG_RST;
      irq <= 1'b0;
    end else begin
      if (wr_en && paddr == ACC_OFF_IRQ_STS) begin
        irq_sts_reg <= (irq_sts_reg & ~pwdata[2:0]) | evt_set;
      end else begin
        irq_sts_reg <= irq_sts_reg | evt_set;
      end
      if (wr_en && paddr == ACC_OFF_IRQ_MSK) begin
        irq_msk_reg <= pwdata[2:0];
      end
      // Registered for a clean pin, so the line lags the status by one cycle
      irq <= |(irq_sts_reg & irq_msk_reg);
    end
  end

  // Analog side controls, registered so every output leaves a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_enable <= 3'h0;
      plus_ladder_sel <= 3'h0;
      minus_src <= 9'h000;
      channel_output_pin <= 3'h0;
      channel_output_oe <= 3'h0;
    end else begin
      for (int i = 0; i < ACC_NCH; i++) begin
        cmp_enable[i] <= ctrl_reg[i][ACC_B_ENABLE];
        plus_ladder_sel[i] <= ctrl_reg[i][ACC_B_PLUS];
        minus_src[3*i +: 3] <= minus_decode(ctrl_reg[i][ACC_B_MINUS_HI:ACC_B_MINUS_LO], i);
        channel_output_pin[i] <= ctrl_reg[i][ACC_B_DRIVE] & result_next[i];
        // direction bit still gates the driver
        channel_output_oe[i] <= ctrl_reg[i][ACC_B_DRIVE] & ~pin_dir_input[i];
      end
    end
  end

  AST_CTRL_WR: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && paddr == ACC_OFF_CTRL1 |=> ctrl_reg[0] == $past(pwdata[7:0]) ##1 cmp_enable[0] == $past(pwdata[7], 2))
    else $error("control write not applied");

  // pin copy equals the polarity-adjusted result
  AST_INV: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_reg[0][ACC_B_DRIVE] && $stable(ctrl_reg[0]) |=> channel_output_pin[0] == result_reg[0])
    else $error("pin result differs from status result");

  // disabled channel reads as its polarity bit
  AST_OFF_LOW: assert property (@(posedge pclk) disable iff (!presetn)
    !ctrl_reg[1][ACC_B_ENABLE] |=> result_reg[1] == $past(ctrl_reg[1][ACC_B_INVERT]))
    else $error("disabled channel result not held");

  // result follows the raw input three flops later
  AST_SYNC: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_reg[0] == 8'h80 [*4] |-> result_reg[0] == $past(cmp_raw[0], 3))
    else $error("synchroniser latency wrong");

  AST_RISE: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_reg[2][7:3] == 5'h11 && en_prev_reg[2] && $rose(result_reg[2]) |=> flag_reg[2] && irq_sts_reg[2])
    else $error("rise event missed");

  AST_NONE: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_reg[0][ACC_B_EDGE_HI:ACC_B_EDGE_LO] == ACC_EDGE_NONE && !auto_set[0] |-> !hit[0])
    else $error("event in disabled mode");

  AST_AUTO: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && paddr == ACC_OFF_CTRL2 && pwdata[4:3] == ACC_EDGE_ANY |=> flag_reg[1])
    else $error("any-change selection did not set flag");

  // writing zero clears without a concurrent event
  AST_FLAG_CLR: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && paddr == ACC_OFF_FLAG && evt_set == 3'h0 |=> flag_reg == $past(pwdata[2:0]))
    else $error("flag write wrong");

  AST_STAT: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && !pready && !pwrite && paddr == ACC_OFF_STAT |=> prdata[4:0] == 5'h00 && pready)
    else $error("status low bits not zero");

  AST_OE: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> channel_output_oe[2] == ($past(ctrl_reg[2][ACC_B_DRIVE]) && !$past(pin_dir_input[2])))
    else $error("output enable wrong");

  AST_MASKED: assert property (@(posedge pclk) disable iff (!presetn)
    hit[0] && !irq_msk_reg[0] |=> flag_reg[0] ##1 !irq || irq_sts_reg[1] || irq_sts_reg[2])
    else $error("masked event lost");

  AST_IRQ_LVL: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> irq == $past(|(irq_sts_reg & irq_msk_reg)))
    else $error("interrupt line wrong");

  AST_READY_PULSE: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("ready longer than one cycle");

  AST_EN_OUT: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> cmp_enable ==
    $past({ctrl_reg[2][ACC_B_ENABLE], ctrl_reg[1][ACC_B_ENABLE], ctrl_reg[0][ACC_B_ENABLE]}))
    else $error("comparator enable wrong");

  AST_PLUS: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> plus_ladder_sel[1] == $past(ctrl_reg[1][ACC_B_PLUS]))
    else $error("plus source select wrong");

  AST_MINUS_C1: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_reg[0][ACC_B_MINUS_HI:ACC_B_MINUS_LO] == ACC_MINUS_EXTRA |=> minus_src[2:0] == ACC_SRC_SHARED_B)
    else $error("channel one extra source wrong");

  AST_MINUS_C2: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_reg[1][ACC_B_MINUS_HI:ACC_B_MINUS_LO] == ACC_MINUS_EXTRA |=> minus_src[5:3] == ACC_SRC_CH2_D)
    else $error("channel two extra source wrong");

  AST_MINUS_BGAP: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_reg[2][ACC_B_MINUS_HI:ACC_B_MINUS_LO] == ACC_MINUS_BGAP |=> minus_src[8:6] == ACC_SRC_BGAP)
    else $error("bandgap source wrong");

  AST_PIN_OFF: assert property (@(posedge pclk) disable iff (!presetn)
    !ctrl_reg[0][ACC_B_DRIVE] |=> !channel_output_pin[0] && !channel_output_oe[0])
    else $error("pin driven while internal only");

  AST_QUIET: assert property (@(posedge pclk) disable iff (!presetn)
    !(ctrl_reg[2][ACC_B_ENABLE] && en_prev_reg[2]) |-> !hit[2])
    else $error("event on disabled channel");

  AST_FALL: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_reg[0][ACC_B_ENABLE] && en_prev_reg[0] && ctrl_reg[0][ACC_B_EDGE_HI:ACC_B_EDGE_LO] == ACC_EDGE_FALL &&
    $fell(result_reg[0]) |=> flag_reg[0] && irq_sts_reg[0])
    else $error("fall event missed");

  AST_SET_WINS: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && paddr == ACC_OFF_FLAG |=> (flag_reg & $past(evt_set)) == $past(evt_set))
    else $error("event lost under flag write");

  AST_W1C: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && paddr == ACC_OFF_IRQ_STS && evt_set == 3'h0 |=>
    irq_sts_reg == ($past(irq_sts_reg) & ~$past(pwdata[2:0])))
    else $error("interrupt status clear wrong");

  AST_STAT_HI: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && !pready && !pwrite && paddr == ACC_OFF_STAT |=> prdata[7:5] == $past(result_reg))
    else $error("status result bits wrong");

  COV_RISE: cover property (@(posedge pclk) disable iff (!presetn) hit[0] && result_reg[0]);
  COV_FALL: cover property (@(posedge pclk) disable iff (!presetn) hit[1] && !result_reg[1]);
  COV_IRQ: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
  COV_ERR: cover property (@(posedge pclk) disable iff (!presetn) pslverr);
  COV_AUTO: cover property (@(posedge pclk) disable iff (!presetn) auto_set[1]);

endmodule // acc_top

// ===== acc_analog_model.sv
module acc_analog_model (
  input wire logic pclk,
  input wire logic [2:0] cmp_enable,
  input wire logic [2:0] plus_ladder_sel,
  input wire logic [8:0] minus_src,
  input wire logic [23:0] ext_a,
  output logic [2:0] cmp_raw
);
  timeunit 1ns;
  timeprecision 1ps;
  logic tgl = 1'b0;
  logic [7:0] plus_v;
  logic [7:0] minus_v;
  // A powered-down comparator gives no valid level, so show a moving one
  always @(posedge pclk) begin
    tgl <= ~tgl;
  end
  always_comb begin
    plus_v = 8'h00;
    minus_v = 8'h00;
    for (int i = 0; i < 3; i++) begin
      plus_v = plus_ladder_sel[i] ? 8'h64 : ext_a[8*i+:8];
      case (minus_src[3*i+:3])
        3'h0: minus_v = 8'h3c;
        3'h1: minus_v = 8'h8c;
        3'h2: minus_v = 8'h50;
        3'h3: minus_v = 8'h78;
        default: minus_v = 8'h32;
      endcase
      cmp_raw[i] = cmp_enable[i] ? (plus_v > minus_v) : tgl;
    end
  end
endmodule // acc_analog_model

// ===== testbench.sv
module testbench
  import acc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic pready, pslverr, irq, err;
  logic [2:0] cmp_raw, pin_dir_input = 3'h0, cmp_enable, plus_ladder_sel, channel_output_pin, channel_output_oe;
  logic [8:0] minus_src;
  logic [23:0] ext_a = 24'h0;
  logic [2:0] m;
  int fails = 0, checks = 0, cyc = 0;
  acc_top acc_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .cmp_raw, .pin_dir_input, .cmp_enable, .plus_ladder_sel, .minus_src, .channel_output_pin, .channel_output_oe,
    .irq);
  acc_analog_model acc_analog_model_inst (.pclk, .cmp_enable, .plus_ladder_sel, .minus_src, .ext_a, .cmp_raw);
  always #5 pclk = ~pclk;
  task results;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      results;
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp, input string s);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t %s got %h exp %h", $time, s, got, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e, input string s);
    apb(1'b0, a, 32'h0);
    chk(rdat, e, s);
  endtask
  task wt(input int n);
    repeat (n) @(posedge pclk);
  endtask
  initial begin
    wt(4);
    presetn <= 1'b1;
    for (int c = 0; c < 3; c++) rd(ACC_OFF_CTRL1 + 8'(4 * c), 32'h0, "ctrl reset");
    rd(ACC_OFF_STAT, 32'h0, "status reset");
    $display("reset test done");
    for (int c = 0; c < 3; c++) begin
      for (int k = 0; k < 4; k++) begin
        wr(ACC_OFF_CTRL1 + 8'(4 * c), 32'h84 | 32'(k));
        rd(ACC_OFF_CTRL1 + 8'(4 * c), 32'h84 | 32'(k), "ctrl readback");
        m = (k == 2) ? ((c == 1) ? 3'h3 : 3'h2) : ((k == 3) ? 3'h4 : 3'(k));
        chk(32'(minus_src[3*c+:3]), 32'(m), "minus select");
        chk(32'({cmp_enable[c], plus_ladder_sel[c]}), 32'h3, "enable and plus");
      end
    end
    // Response time after the source change
    wt(8);
    rd(ACC_OFF_STAT, 32'he0, "ladder over bandgap");
    $display("select test done");
    for (int e = 0; e < 4; e++) begin
      wr(ACC_OFF_CTRL1, 32'h80 | 32'(e << 3));
      rd(ACC_OFF_FLAG, 32'(e == 3), "auto flag");
      wr(ACC_OFF_FLAG, 32'h0);
      ext_a[7:0] <= 8'hc8;
      wt(8);
      rd(ACC_OFF_FLAG, 32'(e & 1), "rise event");
      wr(ACC_OFF_FLAG, 32'h0);
      ext_a[7:0] <= 8'h00;
      wt(8);
      rd(ACC_OFF_FLAG, 32'(e >> 1), "fall event");
      wr(ACC_OFF_FLAG, 32'h0);
    end
    wr(ACC_OFF_FLAG, 32'h7);
    rd(ACC_OFF_FLAG, 32'h7, "flag set by write");
    wr(ACC_OFF_FLAG, 32'h0);
    rd(ACC_OFF_FLAG, 32'h0, "flag cleared");
    $display("event test done");
    wr(ACC_OFF_IRQ_STS, 32'h7);
    rd(ACC_OFF_IRQ_STS, 32'h0, "status w1c");
    wr(ACC_OFF_CTRL1, 32'h88);
    ext_a[7:0] <= 8'hc8;
    wt(8);
    chk(32'(irq), 32'h0, "masked irq");
    rd(ACC_OFF_IRQ_STS, 32'h1, "irq status");
    wr(ACC_OFF_IRQ_MSK, 32'h1);
    wt(2);
    chk(32'(irq), 32'h1, "irq raised");
    wr(ACC_OFF_IRQ_STS, 32'h1);
    wt(2);
    chk(32'(irq), 32'h0, "irq cleared");
    ext_a[7:0] <= 8'h00;
    $display("irq test done");
    wr(ACC_OFF_CTRL1, 32'he0);
    wt(8);
    rd(ACC_OFF_STAT, 32'he0, "inverted low");
    chk(32'({channel_output_pin[0], channel_output_oe[0]}), 32'h3, "pin high");
    ext_a[7:0] <= 8'hc8;
    wt(8);
    rd(ACC_OFF_STAT, 32'hc0, "inverted high");
    chk(32'({channel_output_pin[0], channel_output_oe[0]}), 32'h1, "pin low");
    pin_dir_input <= 3'h1;
    wt(3);
    chk(32'(channel_output_oe[0]), 32'h0, "pin as input");
    pin_dir_input <= 3'h0;
    $display("pin test done");
    wr(ACC_OFF_CTRL1, 32'h18);
    wr(ACC_OFF_FLAG, 32'h0);
    wt(8);
    rd(ACC_OFF_FLAG, 32'h0, "no events disabled");
    rd(ACC_OFF_STAT, 32'hc0, "disabled low");
    apb(1'b0, 8'h1c, 32'h0);
    chk({31'h0, err}, 32'h1, "unmapped error");
    chk(rdat, 32'h0, "unmapped data");
    $display("disable test done");
    // Channel three rises on its own pin, then channel two is switched off
    wr(ACC_OFF_CTRL3, 32'h88);
    wt(8);
    ext_a[23:16] <= 8'hc8;
    wt(8);
    rd(ACC_OFF_FLAG, 32'h4, "channel three rise");
    wr(ACC_OFF_CTRL2, 32'h18);
    rd(ACC_OFF_FLAG, 32'h6, "auto flag channel two");
    chk(32'(cmp_enable), 32'h4, "only channel three on");
    $display("channel test done");
    presetn <= 1'b0;
    wt(2);
    presetn <= 1'b1;
    rd(ACC_OFF_CTRL3, 32'h0, "ctrl after reset");
    rd(ACC_OFF_FLAG, 32'h0, "flags after reset");
    rd(ACC_OFF_STAT, 32'h0, "status after reset");
    chk(32'({irq, cmp_enable}), 32'h0, "outputs after reset");
    $display("second reset test done");
    results;
  end
endmodule // testbench
